// [addr_gen.sv]
`timescale 1ns/100ps
// Notes on behaviour
// - short absolute: main page register above 16-bit constant forms 23-bit address.
// - short absolute and port absolute operands never issue in parallel.
// - full absolute takes 23 low bits of 3-byte extension; never paired.
// - single-word operand via full absolute constant refused inside repeat.
// - port absolute uses constant as I/O address; delay instruction refuses it.
// - stack-relative select 0 gives page-relative, 1 gives stack-relative direct.
// - register-bit and peripheral-page direct ignore the stack-relative select.
// - page-relative: main page on top, local base plus offset below.
// - local base may start a 128-word page anywhere in the main page.
// - direct offset computed differently for data memory and mapped registers.
// - page registers load separately or as one extended value.
// - stack-relative: stack page on top, stack pointer plus offset below.
// - stack page and pointer load separately or as one extended value.
// - register-bit offset counts from the least significant bit.
// - register bits only for bit instructions, one or two bits, listed registers.
// - peripheral direct: 9-bit peripheral page above 7-bit word offset.
// - I/O access with port qualifier, in parallel or not, else data memory.
// - single-word operand moves one 16-bit word to the mode's space.
// - long-word operand moves 32 bits from data memory or mapped registers.
// - dual operand two 16-bit data accesses; coefficient word or long.
module addr_gen
    import addr_gen_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic opValid,
    input wire addr_gen_pkg::mode_t opMode,
    input wire addr_gen_pkg::size_t opSize,
    input wire logic [ExtW-1:0] opConstant,
    input wire logic [OffW-1:0] opOffset,
    input wire logic [BitOffW-1:0] opBitOffset,
    input wire logic [RegSelW-1:0] opRegSel,
    input wire logic opBitPair,
    input wire logic opBitInstr,
    input wire logic opMmapQual,
    input wire logic opPortQual,
    input wire logic opParallel,
    input wire logic opRepeated,
    input wire logic opDelayInstr,
    input wire logic stackRelativeSelect,
    input wire addr_gen_pkg::load_t pageLoad,
    input wire addr_gen_pkg::load_t stackLoad,
    input wire logic periphLoad,
    input wire logic [ExtW-1:0] loadValue,
    output logic accValid,
    output logic accError,
    output logic [AddrW-1:0] accAddr,
    output logic [AddrW-1:0] accAddrSecond,
    output logic [LowW-1:0] accIoAddr,
    output addr_gen_pkg::space_t accSpace,
    output addr_gen_pkg::size_t accSize,
    output logic [RegSelW-1:0] accRegSel,
    output logic [BitOffW-1:0] accBitIndex,
    output logic accBitPair
);
    import addr_gen_pkg::*;

    page_regs_if regs();

    page_regs u_page_regs (
        .mclk(mclk),
        .nrst(nrst),
        .pageLoad(pageLoad),
        .stackLoad(stackLoad),
        .periphLoad(periphLoad),
        .loadValue(loadValue),
        .regs(regs)
    );

    // ***************************
    // decode helpers
    // ***************************
    // offset inside the mapped-register area is absolute; data offset is relative to local base
    function automatic logic [LowW-1:0] low_sum(input logic [LowW-1:0] base, input logic [OffW-1:0] off);
        low_sum = LowW'(base + LowW'(off)); // wraps, no carry to the page
    endfunction

    function automatic logic needs_long_const(input mode_t m);
        needs_long_const = (m == ModeAbs16) || (m == ModeAbs23) || (m == ModePortAbs);
    endfunction

    logic [LowW-1:0] pageLow;
    logic [LowW-1:0] stackLow;
    logic [AddrW-1:0] addrD;
    logic [LowW-1:0] ioD;
    space_t spaceD;
    logic errD;

    assign pageLow = low_sum(regs.localBase, opOffset);
    assign stackLow = low_sum(regs.stackPtr, opOffset);

    // ***************************
    // address formation
    // ***************************
    always_comb begin
        addrD = '0;
        ioD = '0;
        spaceD = SpaceData;
        errD = 1'b0;
        case (opMode)
            ModeAbs16: begin
                addrD = {regs.mainPage, opConstant[LowW-1:0]};
                spaceD = opMmapQual ? SpaceMmr : SpaceData;
            end
            ModeAbs23: begin
                addrD = opConstant[AddrW-1:0]; // top extension bit dropped
                spaceD = opMmapQual ? SpaceMmr : SpaceData;
                errD = opRepeated && (opSize == SizeWord);
            end
            ModePortAbs: begin
                ioD = opConstant[LowW-1:0];
                spaceD = SpaceIo;
                errD = opDelayInstr;
            end
            ModeDirect: begin
                if (stackRelativeSelect) begin
                    addrD = {regs.stackPage, stackLow};
                    spaceD = SpaceData;
                end else if (opMmapQual) begin
                    // mapped registers sit at the bottom of page 0
                    addrD = AddrW'(opOffset & MmrOffMask);
                    spaceD = SpaceMmr;
                end else begin
                    addrD = {regs.mainPage, pageLow};
                    spaceD = SpaceData;
                end
            end
            ModeRegBit: begin
                // select bit is not consulted here
                spaceD = SpaceReg;
                errD = !opBitInstr || (opRegSel > RegSelLast);
            end
            ModePeriph: begin
                ioD = {regs.periphPage, opOffset};
                spaceD = opPortQual ? SpaceIo : SpaceData;
                addrD = opPortQual ? '0 : {regs.mainPage, pageLow};
            end
            default: begin
                errD = 1'b1;
            end
        endcase
        if (spaceD == SpaceIo && opSize != SizeWord) begin
            errD = 1'b1; // only single words reach I/O
        end
        if ((opSize == SizeDual || opSize == SizeCoef) && spaceD != SpaceData) begin
            errD = 1'b1;
        end
        if (needs_long_const(opMode) && opParallel) begin
            errD = 1'b1;
        end
    end

    // ***************************
    // registered outputs
    // ***************************
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            accValid <= 1'b0;
            accError <= 1'b0;
        end else begin
            accValid <= opValid && !errD;
            accError <= opValid && errD;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            accAddr <= '0;
            accAddrSecond <= '0;
            accIoAddr <= '0;
            accSpace <= SpaceData;
            accSize <= SizeWord;
        end else if (opValid) begin
            accAddr <= addrD;
            // long and dual-word second word; low field wraps
            accAddrSecond <= {addrD[AddrW-1:LowW], LowW'(addrD[LowW-1:0] + LowW'(1))};
            accIoAddr <= ioD;
            accSpace <= spaceD;
            accSize <= opSize;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            accRegSel <= '0;
            accBitIndex <= '0;
            accBitPair <= 1'b0;
        end else if (opValid && opMode == ModeRegBit) begin
            accRegSel <= opRegSel;
            accBitIndex <= opBitOffset; // counted from the LSB
            accBitPair <= opBitPair;
        end
    end

    // ***************************
    // checks
    // ***************************
    sequence s_abs16_req;
        opValid && opMode == ModeAbs16 && !opParallel;
    endsequence

    a_abs16_concat: assert property (@(posedge mclk) disable iff (!nrst)
        s_abs16_req |=> accAddr == {$past(regs.mainPage), $past(opConstant[LowW-1:0])})
        else $error("short absolute address wrong");
    a_parallel_const: assert property (@(posedge mclk) disable iff (!nrst)
        (opValid && needs_long_const(opMode) && opParallel) |=> accError && !accValid)
        else $error("long constant in parallel not refused");
    a_abs23_drop: assert property (@(posedge mclk) disable iff (!nrst)
        (opValid && opMode == ModeAbs23) |=> accAddr == $past(opConstant[AddrW-1:0]))
        else $error("full absolute address wrong");
    a_repeat_abs23: assert property (@(posedge mclk) disable iff (!nrst)
        (opValid && opMode == ModeAbs23 && opRepeated && opSize == SizeWord) |=> accError)
        else $error("repeated full absolute word not refused");
    a_port_delay: assert property (@(posedge mclk) disable iff (!nrst)
        (opValid && opMode == ModePortAbs && opDelayInstr) |=> accError)
        else $error("delay with port absolute not refused");
    a_stack_direct: assert property (@(posedge mclk) disable iff (!nrst)
        (opValid && opMode == ModeDirect && stackRelativeSelect) |=>
        accAddr == {$past(regs.stackPage), LowW'($past(regs.stackPtr) + LowW'($past(opOffset)))})
        else $error("stack-relative address wrong");
    a_page_direct: assert property (@(posedge mclk) disable iff (!nrst)
        (opValid && opMode == ModeDirect && !stackRelativeSelect && !opMmapQual) |=>
        accAddr[AddrW-1:LowW] == $past(regs.mainPage) && accSpace == SpaceData)
        else $error("page-relative address wrong");
    a_periph_addr: assert property (@(posedge mclk) disable iff (!nrst)
        (opValid && opMode == ModePeriph && opPortQual && opSize == SizeWord) |=>
        accIoAddr == {$past(regs.periphPage), $past(opOffset)} && accSpace == SpaceIo)
        else $error("peripheral address wrong");
    a_regbit_gate: assert property (@(posedge mclk) disable iff (!nrst)
        (opValid && opMode == ModeRegBit && !opBitInstr) |=> accError)
        else $error("register bit outside bit instruction not refused");
endmodule // addr_gen

// [addr_gen_pkg.sv]
package addr_gen_pkg;
    localparam int PageW = 7;
    localparam int LowW = 16;
    localparam int AddrW = 23;
    localparam int PeriphW = 9;
    localparam int OffW = 7;
    localparam int BitOffW = 6;
    localparam int ExtW = 24;
    localparam int RegSelW = 5;
    localparam logic [PageW-1:0] PageReset = 7'h00;
    localparam logic [LowW-1:0] LowReset = 16'h0000;
    localparam logic [PeriphW-1:0] PeriphReset = 9'h000;
    localparam logic [AddrW-1:0] MmrLast = 23'h00005F;
    localparam logic [OffW-1:0] MmrOffMask = 7'h7F;
    localparam logic [LowW-1:0] LocalPageMask = 16'hFF80;
    localparam logic [RegSelW-1:0] RegSelLast = 5'h0F;

    typedef enum logic [2:0] {
        ModeNone,
        ModeAbs16,
        ModeAbs23,
        ModePortAbs,
        ModeDirect,
        ModeRegBit,
        ModePeriph
    } mode_t;

    typedef enum logic [1:0] {
        SizeWord,
        SizeLong,
        SizeDual,
        SizeCoef
    } size_t;

    typedef enum logic [1:0] {
        SpaceData,
        SpaceIo,
        SpaceMmr,
        SpaceReg
    } space_t;

    typedef enum logic [1:0] {
        LoadNone,
        LoadHigh,
        LoadLow,
        LoadBoth
    } load_t;
endpackage

// [page_regs_if.sv]
`timescale 1ns/100ps
interface page_regs_if;
    import addr_gen_pkg::*;
    logic [PageW-1:0] mainPage;
    logic [LowW-1:0] localBase;
    logic [PageW-1:0] stackPage;
    logic [LowW-1:0] stackPtr;
    logic [PeriphW-1:0] periphPage;
    modport owner (output mainPage, localBase, stackPage, stackPtr, periphPage);
    modport user (input mainPage, localBase, stackPage, stackPtr, periphPage);
endinterface

// [page_regs.sv]
`timescale 1ns/100ps
module page_regs
    import addr_gen_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire addr_gen_pkg::load_t pageLoad,
    input wire addr_gen_pkg::load_t stackLoad,
    input wire logic periphLoad,
    input wire logic [ExtW-1:0] loadValue,
    page_regs_if.owner regs
);
    logic [PageW-1:0] mainPage_q;
    logic [LowW-1:0] localBase_q;
    logic [PageW-1:0] stackPage_q;
    logic [LowW-1:0] stackPtr_q;
    logic [PeriphW-1:0] periphPage_q;

    // ***************************
    // extended page register
    // ***************************
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mainPage_q <= PageReset;
            localBase_q <= LowReset;
        end else begin
            // high only, low only, or both as one extended value
            if (pageLoad == LoadHigh || pageLoad == LoadBoth) begin
                mainPage_q <= loadValue[LowW +: PageW];
            end
            if (pageLoad == LoadLow || pageLoad == LoadBoth) begin
                localBase_q <= loadValue[LowW-1:0];
            end
        end
    end

    // ***************************
    // extended stack pointer
    // ***************************
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            stackPage_q <= PageReset;
            stackPtr_q <= LowReset;
        end else begin
            if (stackLoad == LoadHigh || stackLoad == LoadBoth) begin
                stackPage_q <= loadValue[LowW +: PageW];
            end
            if (stackLoad == LoadLow || stackLoad == LoadBoth) begin
                stackPtr_q <= loadValue[LowW-1:0];
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            periphPage_q <= PeriphReset;
        end else if (periphLoad) begin
            periphPage_q <= loadValue[PeriphW-1:0];
        end
    end

    assign regs.mainPage = mainPage_q;
    assign regs.localBase = localBase_q;
    assign regs.stackPage = stackPage_q;
    assign regs.stackPtr = stackPtr_q;
    assign regs.periphPage = periphPage_q;

    a_both_load_high: assert property (@(posedge mclk) disable iff (!nrst)
        (pageLoad == LoadBoth) |=> (mainPage_q == $past(loadValue[LowW +: PageW])))
        else $error("extended page load lost high part");
    a_stack_low_only: assert property (@(posedge mclk) disable iff (!nrst)
        (stackLoad == LoadLow) |=> $stable(stackPage_q))
        else $error("stack pointer load disturbed stack page");
endmodule // page_regs

// [access_sink.sv]
`timescale 1ns/100ps
// ****************
// far-side access counter
// ****************
module access_sink
    import addr_gen_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic accValid,
    input wire addr_gen_pkg::space_t accSpace,
    output int ioCount,
    output int dataCount
);
    import addr_gen_pkg::*;
    // io space only answers accepted io accesses
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ioCount <= 0;
            dataCount <= 0;
        end else if (accValid === 1'b1) begin
            if (accSpace === SpaceIo) ioCount <= ioCount + 1;
            else dataCount <= dataCount + 1;
        end
    end
endmodule // access_sink

// [absolute_direct_address_gen_tb.sv]
`timescale 1ns/100ps
module absolute_direct_address_gen_tb;
    import addr_gen_pkg::*;
    logic mclk, nrst, opValid, opBitPair, opBitInstr, opMmapQual, opPortQual;
    logic opParallel, opRepeated, opDelayInstr, stackRelativeSelect, periphLoad;
    mode_t opMode;
    size_t opSize, accSize;
    load_t pageLoad, stackLoad;
    logic [ExtW-1:0] opConstant, loadValue;
    logic [OffW-1:0] opOffset;
    logic [BitOffW-1:0] opBitOffset, accBitIndex;
    logic [RegSelW-1:0] opRegSel, accRegSel;
    logic accValid, accError, accBitPair;
    logic [AddrW-1:0] accAddr, accAddrSecond;
    logic [LowW-1:0] accIoAddr;
    space_t accSpace;
    int ioCount, dataCount, failures, cmpCount;

    addr_gen dut_u (.mclk(mclk), .nrst(nrst), .opValid(opValid), .opMode(opMode), .opSize(opSize),
        .opConstant(opConstant), .opOffset(opOffset), .opBitOffset(opBitOffset), .opRegSel(opRegSel),
        .opBitPair(opBitPair), .opBitInstr(opBitInstr), .opMmapQual(opMmapQual), .opPortQual(opPortQual),
        .opParallel(opParallel), .opRepeated(opRepeated), .opDelayInstr(opDelayInstr),
        .stackRelativeSelect(stackRelativeSelect), .pageLoad(pageLoad), .stackLoad(stackLoad),
        .periphLoad(periphLoad), .loadValue(loadValue), .accValid(accValid), .accError(accError),
        .accAddr(accAddr), .accAddrSecond(accAddrSecond), .accIoAddr(accIoAddr), .accSpace(accSpace),
        .accSize(accSize), .accRegSel(accRegSel), .accBitIndex(accBitIndex), .accBitPair(accBitPair));
    access_sink sink_u (.mclk(mclk), .nrst(nrst), .accValid(accValid), .accSpace(accSpace),
        .ioCount(ioCount), .dataCount(dataCount));

    // ****************
    // helpers
    // ****************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", cmpCount, failures);
        if (failures == 0 && cmpCount > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic clr();
        {opBitPair, opBitInstr, opMmapQual, opPortQual, opParallel} = 5'h00;
        {opRepeated, opDelayInstr, stackRelativeSelect, periphLoad} = 4'h0;
        opMode = ModeAbs16;
        opSize = SizeWord;
        pageLoad = LoadNone;
        stackLoad = LoadNone;
        {opConstant, loadValue} = 48'h0;
        {opOffset, opBitOffset, opRegSel} = 18'h0;
    endtask
    // result pulse stands from the taking edge on; sampled at mid-cycle, half a cycle after it
    task automatic fire(input logic expOk);
        @(negedge mclk) opValid = 1'b1;
        @(negedge mclk) opValid = 1'b0;
        check(accValid, expOk);
        check(accError, !expOk);
    endtask
    task automatic ld(input load_t pl, input load_t sl, input logic pe, input logic [ExtW-1:0] v);
        @(negedge mclk);
        pageLoad = pl;
        stackLoad = sl;
        periphLoad = pe;
        loadValue = v;
        // only the load strobes drop; operand fields stay with the scenario
        @(negedge mclk);
        pageLoad = LoadNone;
        stackLoad = LoadNone;
        periphLoad = 1'b0;
    endtask

    // ****************
    // scenarios
    // ****************
    task automatic t_abs();
        ld(LoadHigh, LoadNone, 1'b0, 24'h050000);
        opConstant = 24'h001234;
        fire(1'b1);
        check(accAddr, 23'h051234);
        check(accSpace, SpaceData);
        opParallel = 1'b1;
        fire(1'b0);
        opMode = ModeAbs23;
        fire(1'b0);
        opParallel = 1'b0;
        opConstant = 24'hFABCDE;
        fire(1'b1);
        check(accAddr, 23'h7ABCDE);
        opRepeated = 1'b1;
        fire(1'b0);
        opMode = ModePortAbs;
        opRepeated = 1'b0;
        opConstant = 24'h00BEEF;
        fire(1'b1);
        check({accSpace, accIoAddr}, {SpaceIo, 16'hBEEF});
        opDelayInstr = 1'b1;
        fire(1'b0);
        opDelayInstr = 1'b0;
        opParallel = 1'b1;
        fire(1'b0);
        clr();
        $display("test absolute done");
    endtask
    task automatic t_direct();
        ld(LoadLow, LoadNone, 1'b0, 24'h7F0040);
        opMode = ModeDirect;
        opOffset = 7'h10;
        fire(1'b1);
        check(accAddr, 23'h050050);
        ld(LoadBoth, LoadBoth, 1'b0, 24'h03FFF0);
        opMode = ModeDirect;
        opOffset = 7'h20;
        fire(1'b1);
        check(accAddr, 23'h030010);
        ld(LoadNone, LoadBoth, 1'b0, 24'h11FFFF);
        opMode = ModeDirect;
        {opOffset, stackRelativeSelect} = {7'h7F, 1'b1};
        fire(1'b1);
        check(accAddr, 23'h11007E);
        ld(LoadNone, LoadLow, 1'b0, 24'h000100);
        ld(LoadNone, LoadHigh, 1'b0, 24'h120000);
        opMode = ModeDirect;
        {opOffset, stackRelativeSelect} = {7'h05, 1'b1};
        fire(1'b1);
        check(accAddr, 23'h120105);
        {stackRelativeSelect, opMmapQual, opOffset} = {1'b0, 1'b1, 7'h2A};
        fire(1'b1);
        check({accSpace, accAddr}, {SpaceMmr, 23'h00002A});
        clr();
        $display("test direct done");
    endtask
    task automatic t_sizes();
        opConstant = 24'h00FFFF;
        opSize = SizeLong;
        fire(1'b1);
        check({accSize, accAddrSecond}, {SizeLong, 23'h030000});
        opMode = ModePortAbs;
        fire(1'b0);
        opMode = ModeDirect;
        opMmapQual = 1'b1;
        opSize = SizeDual;
        fire(1'b0);
        opMode = ModeAbs16;
        opMmapQual = 1'b0;
        opSize = SizeCoef;
        fire(1'b1);
        check(accSize, SizeCoef);
        opMode = ModeNone;
        fire(1'b0);
        clr();
        $display("test sizes done");
    endtask
    task automatic t_bits();
        opMode = ModeRegBit;
        {opBitInstr, opRegSel, opBitOffset, opBitPair} = {1'b1, RegSelLast, 6'h03, 1'b1};
        fire(1'b1);
        check({accSpace, accRegSel, accBitIndex, accBitPair}, {SpaceReg, 5'h0F, 6'h03, 1'b1});
        {stackRelativeSelect, opBitOffset, opBitPair} = {1'b1, 6'h00, 1'b0};
        fire(1'b1);
        check({accRegSel, accBitIndex, accBitPair}, {5'h0F, 6'h00, 1'b0});
        opRegSel = 5'h10;
        fire(1'b0);
        {opRegSel, opBitInstr} = {5'h00, 1'b0};
        fire(1'b0);
        ld(LoadNone, LoadNone, 1'b1, 24'h0001A3);
        opMode = ModePeriph;
        {opOffset, opPortQual, stackRelativeSelect} = {7'h05, 1'b1, 1'b1};
        fire(1'b1);
        check({accSpace, accIoAddr}, {SpaceIo, 16'hD185});
        opPortQual = 1'b0;
        stackRelativeSelect = 1'b0;
        fire(1'b1);
        check({accSpace, accAddr}, {SpaceData, 23'h03FFF5});
        check(ioCount, 2);
        // sink counts one edge late: the last data access is not in yet
        check(dataCount, 32'h0000000B);
        clr();
        $display("test bits and ports done");
    endtask

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        report_and_stop();
    end
    initial begin
        failures = 0;
        cmpCount = 0;
        nrst = 1'b0;
        opValid = 1'b0;
        clr();
        repeat (4) @(negedge mclk);
        check({accValid, accError, accSpace, accSize}, 6'h00);
        nrst = 1'b1;
        t_abs();
        t_direct();
        t_sizes();
        t_bits();
        report_and_stop();
    end
endmodule // absolute_direct_address_gen_tb
